// *** src/odsp_pkg.sv ***
// Package: constants and carrier types for the octal converter serial port
package odsp_pkg;
  localparam int unsigned WORD_W     = 16;         // Input shift register width
  localparam int unsigned CNT_W      = 5;          // Falling-edge counter width
  localparam logic [4:0]  CNT_FULL   = 5'h10;      // Sixteenth falling edge
  localparam logic [4:0]  CNT_ABORT  = 5'h0e;      // Below fifteen edges: abort
  localparam logic [4:0]  CNT_SAT    = 5'h11;      // Counter saturates here
  localparam logic [15:0] WORD_RST   = 16'h0000;   // Reset value of words
  localparam int unsigned DEPTH      = 1;          // Latched word store depth

  // Frame state, one-hot
  typedef enum logic [2:0] {
    ODSP_IDLE  = 3'b001,
    ODSP_SHIFT = 3'b010,
    ODSP_DONE  = 3'b100
  } odsp_state_e;

  // Synchronised pin levels
  typedef struct packed {
    logic sync_n;
    logic sclk;
    logic din;
  } odsp_pins_s;
endpackage

// *** src/odsp_word_mem.sv ***
// Word store: holds the last applied word, read data from a register
`timescale 1ns/1ps
module odsp_word_mem
  import odsp_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              wr_en,
  input  wire logic [WORD_W-1:0] wr_data,
  output logic      [WORD_W-1:0] rd_data
);
  // Single entry; reset clears it so outputs start at zero
  logic [WORD_W-1:0] mem_r;    // Stored word
  logic [WORD_W-1:0] mem_nxt;  // Next stored word

  // Write port: the word changes only on a commit strobe
  always_comb begin
    mem_nxt = mem_r;
    if (wr_en) begin
      mem_nxt = wr_data;
    end
  end

  // Storage register, synchronous reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      mem_r <= WORD_RST;
    end else begin
      mem_r <= mem_nxt;
    end
  end
  assign rd_data = mem_r;
endmodule

// *** src/odsp_top.sv ***
// Top: serial input port of the octal converter, oversampled by mclk
// Function
// - Strobe low starts frame; capture on falls
// - Sixteen-bit register; sample only after strobe
// - Strobe rise after sixteen falls applies word
// - Early strobe rise aborts, nothing changes
// - Serial out silent until sixteen edges
// - Word output zero after reset until write
`timescale 1ns/1ps
module odsp_top
  import odsp_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              sync_n,     // Frame strobe pin, active low
  input  wire logic              sclk,       // Shift clock pin
  input  wire logic              din,        // Serial data pin
  output logic                   dout,       // Daisy-chain serial output
  output logic      [WORD_W-1:0] word_out,   // Applied word
  output logic                   word_upd    // One-cycle update pulse
);
  // All module state in one struct
  typedef struct packed {
    odsp_pins_s        s1;      // First synchroniser stage
    odsp_pins_s        s2;      // Second synchroniser stage
    logic              sclk_d;  // Previous synchronised clock
    logic              sync_d;  // Previous synchronised strobe
    odsp_state_e       st;      // Frame state
    logic [CNT_W-1:0]  cnt;     // Falling edges this frame
    logic [WORD_W-1:0] sh;      // Input shift register
    logic              dout;    // Serial output flop
    logic              upd;     // Update pulse flop
  } odsp_st_s;

  odsp_st_s          q_r;       // Registered state
  odsp_st_s          q_nxt;     // Next state
  logic              fall;      // Shift clock falling edge seen
  logic              rise_sy;   // Strobe rising edge seen
  logic [WORD_W-1:0] mem_q;     // Stored word from memory
  logic              mem_we;    // Commit strobe to memory

  // Edge detectors read only second-stage flops and their delayed copies
  assign fall    = q_r.sclk_d & ~q_r.s2.sclk;
  assign rise_sy = ~q_r.sync_d & q_r.s2.sync_n;

  // Each stage copies the one before it; a skipped stage would let a
  // metastable pin level reach the edge detectors
  AST_SYNC: assert property (@(posedge mclk) disable iff (rst)
    q_r.s2 == $past(q_r.s1))
    else $error("synchroniser stage skipped");

  // Next-state logic
  always_comb begin
    q_nxt        = q_r;
    q_nxt.s1     = '{sync_n: sync_n, sclk: sclk, din: din};
    q_nxt.s2     = q_r.s1;
    q_nxt.sclk_d = q_r.s2.sclk;
    q_nxt.sync_d = q_r.s2.sync_n;
    q_nxt.upd    = 1'b0;
    mem_we       = 1'b0;
    case (q_r.st)
      ODSP_IDLE: begin
        // Strobe seen low opens a frame; count restarts
        if (!q_r.s2.sync_n) begin
          q_nxt.st   = ODSP_SHIFT;
          q_nxt.cnt  = '0;
          q_nxt.dout = 1'b0;
        end
      end
      ODSP_SHIFT: begin
        // Strobe rise wins over a fall in the same cycle; the frame is over
        if (rise_sy) begin
          // Commit only complete frames; short frames are dropped
          if (q_r.cnt >= CNT_FULL) begin
            mem_we    = 1'b1;
            q_nxt.upd = 1'b1;
          end else if (q_r.cnt <= CNT_ABORT) begin
            q_nxt.upd = 1'b0;
          end
          // Exactly fifteen edges: treated as aborted too, the safe side
          q_nxt.st   = ODSP_IDLE;
          q_nxt.dout = 1'b0;
        end else if (fall) begin
          // Sample the data only inside the frame
          q_nxt.sh = {q_r.sh[WORD_W-2:0], q_r.s2.din};
          if (q_r.cnt != CNT_SAT) begin
            q_nxt.cnt = q_r.cnt + 5'h01;
          end
          // Past sixteen edges the oldest bit leaves the chain
          if (q_r.cnt >= CNT_FULL) begin
            q_nxt.dout = q_r.sh[WORD_W-1];
          end
        end
      end
      // Illegal code: fall back to idle rather than hang
      default: begin
        q_nxt.st = ODSP_IDLE;
      end
    endcase
  end

  // State register, synchronous reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      q_r        <= '0;
      // Stages start strobe-high so no false frame opens at release
      q_r.s1     <= '{sync_n: 1'b1, sclk: 1'b0, din: 1'b0};
      q_r.s2     <= '{sync_n: 1'b1, sclk: 1'b0, din: 1'b0};
      q_r.sync_d <= 1'b1;
      q_r.st     <= ODSP_IDLE;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Word store: cleared at reset so outputs sit at zero
  odsp_word_mem u_mem (
    .mclk    (mclk),
    .rst     (rst),
    .wr_en   (mem_we),
    .wr_data (q_r.sh),
    .rd_data (mem_q)
  );

  // Every output is a register; no logic sits between flop and pin
  assign word_out = mem_q;
  assign dout     = q_r.dout;
  assign word_upd = q_r.upd;

  // Full frame commits the word on the next cycle
  AST_COMMIT: assert property (@(posedge mclk) disable iff (rst)
    (q_r.st == ODSP_SHIFT && rise_sy && q_r.cnt >= CNT_FULL)
    |=> (word_upd && word_out == $past(q_r.sh)))
    else $error("full frame not applied");

  // Frames of fourteen falls or fewer are dropped whole
  AST_ABORT: assert property (@(posedge mclk) disable iff (rst)
    (q_r.st == ODSP_SHIFT && rise_sy && q_r.cnt <= CNT_ABORT)
    |=> (!word_upd && $stable(word_out)))
    else $error("short frame changed output");

  // Chain output stays low through the first sixteen falls
  AST_SILENT: assert property (@(posedge mclk) disable iff (rst)
    (q_r.st == ODSP_SHIFT && q_r.cnt <= CNT_FULL) |-> !dout)
    else $error("serial out active too early");

  // Word changes only in the cycle that carries the update pulse; pulse
  // and new word appear together, so both are sampled at one edge
  AST_HOLD: assert property (@(posedge mclk) disable iff (rst)
    !word_upd |-> $stable(word_out))
    else $error("output moved without update");

  // Idle falls must not disturb the shift register
  AST_SAMPLE: assert property (@(posedge mclk) disable iff (rst)
    (q_r.st == ODSP_IDLE) |=> $stable(q_r.sh))
    else $error("shift outside frame");

  // Newest bit enters at the bottom on each fall
  AST_SHIFT: assert property (@(posedge mclk) disable iff (rst)
    (q_r.st == ODSP_SHIFT && fall && !rise_sy)
    |=> (q_r.sh[0] == $past(q_r.s2.din)))
    else $error("bit not captured");

  // Beyond sixteen falls the top bit walks out to the chain
  AST_DELAY: assert property (@(posedge mclk) disable iff (rst)
    (q_r.st == ODSP_SHIFT && fall && !rise_sy && q_r.cnt >= CNT_FULL)
    |=> (dout == $past(q_r.sh[WORD_W-1])))
    else $error("delay line bit wrong");

  // A low strobe in idle opens the frame with a clean count
  AST_START: assert property (@(posedge mclk) disable iff (rst)
    (q_r.st == ODSP_IDLE && !q_r.s2.sync_n)
    |=> (q_r.st == ODSP_SHIFT && q_r.cnt == 5'h00))
    else $error("frame did not open");

  // Update is a single-cycle pulse; a second cycle would double-apply
  AST_PULSE: assert property (@(posedge mclk) disable iff (rst)
    word_upd |=> !word_upd)
    else $error("update pulse too long");

  // Any frame short of sixteen falls leaves the outputs alone
  AST_SHORT: assert property (@(posedge mclk) disable iff (rst)
    (q_r.st == ODSP_SHIFT && rise_sy && q_r.cnt < CNT_FULL)
    |=> (!word_upd && $stable(word_out)))
    else $error("short frame reached output");

  // Memory write only at a commit point
  AST_WE: assert property (@(posedge mclk) disable iff (rst)
    mem_we |-> (q_r.st == ODSP_SHIFT && rise_sy && q_r.cnt >= CNT_FULL))
    else $error("word written outside commit");

  // Between frames the chain output rests low
  AST_IDLE_DOUT: assert property (@(posedge mclk) disable iff (rst)
    (q_r.st == ODSP_IDLE) |-> !dout)
    else $error("serial out active between frames");

  // Inside a frame, counter and shift register move only on a shift-clock fall
  AST_STILL: assert property (@(posedge mclk) disable iff (rst)
    (q_r.st == ODSP_SHIFT && !fall && !rise_sy)
    |=> ($stable(q_r.cnt) && $stable(q_r.sh)))
    else $error("shift without clock fall");

  // Each fall adds one to the count until it saturates
  AST_COUNT: assert property (@(posedge mclk) disable iff (rst)
    (q_r.st == ODSP_SHIFT && fall && !rise_sy && q_r.cnt != CNT_SAT)
    |=> (q_r.cnt == $past(q_r.cnt) + 5'h01))
    else $error("fall not counted");

  // Saturation keeps a long chain frame from wrapping below sixteen
  AST_SAT: assert property (@(posedge mclk) disable iff (rst)
    q_r.cnt <= CNT_SAT)
    else $error("fall counter past saturation");

  // Chain output changes only on a shift edge or at frame end
  AST_DOUT_HOLD: assert property (@(posedge mclk) disable iff (rst)
    (q_r.st == ODSP_SHIFT && !fall && !rise_sy) |=> $stable(dout))
    else $error("serial out moved off an edge");

  // Only the two live states are ever reached
  AST_STATE: assert property (@(posedge mclk) disable iff (rst)
    (q_r.st == ODSP_IDLE || q_r.st == ODSP_SHIFT))
    else $error("frame state illegal");
endmodule

// *** dv/odsp_host.sv ***
// Host serial controller model: frame strobe, shift clock and data
`timescale 1ns/1ps
module odsp_host (
  input  wire logic mclk,
  output logic      sync_n,
  output logic      sclk,
  output logic      din
);
  logic active;  // Frame open
  // Idle pins: strobe high, clock high and still
  initial begin
    sync_n = 1'b1;
    sclk   = 1'b1;
    din    = 1'b0;
    active = 1'b0;
  end
  // Released data line toggles so a stale bit never looks valid
  always @(posedge mclk) begin
    if (!active) din <= ~din;
  end
  task automatic open_frame;
    active <= 1'b1;
    sync_n <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  // Data moves on the rise, so it is steady around the fall
  task automatic rise(input logic b);
    if (active) din <= b;
    sclk <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
  task automatic fall;
    sclk <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic close_frame;
    sync_n <= 1'b1;
    active <= 1'b0;
    sclk   <= 1'b1;
  endtask
endmodule

// *** dv/tb.sv ***
// Bench: host model sends frames, a bit queue predicts the chain output and a shift model the word
`timescale 1ns/1ps
module tb
  import odsp_pkg::*;
;
  logic              mclk, rst, sync_n, sclk, din, dout, word_upd;
  logic [WORD_W-1:0] word_out;
  logic [WORD_W-1:0] exp_word;   // Model: last applied word
  logic [WORD_W-1:0] acc;        // Model: shift register
  logic              q[$];       // Model: bits in capture order
  logic [31:0]       v;
  int                mismatches, total_checks, seed, n, cnt;
  int                lens[7] = '{5, 15, 16, 17, 15, 24, 16};
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  odsp_host host (.mclk(mclk), .sync_n(sync_n), .sclk(sclk), .din(din));
  odsp_top dut (.mclk(mclk), .rst(rst), .sync_n(sync_n), .sclk(sclk),
    .din(din), .dout(dout), .word_out(word_out), .word_upd(word_upd));
  task automatic check(input string s, input logic [15:0] e,
                       input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence: short frames abort, full and long ones apply
  initial begin
    rst = 1'b1;
    mismatches = 0;
    total_checks = 0;
    seed = 18020;
    exp_word = '0;
    acc = '0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    check("word_out", '0, word_out);
    foreach (lens[f]) begin
      if (f == 4) begin
        // Mid-run reset: outputs drop to zero and stay until a full frame
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        exp_word = '0;
        check("word_out", exp_word, word_out);
        check("word_upd", '0, word_upd);
        check("dout", '0, dout);
      end
      n = lens[f];
      v = $random(seed);
      host.rise(1'b0);
      host.fall();
      host.rise(1'b0);
      q.delete();
      host.open_frame();
      for (int k = 1; k <= n; k++) begin
        host.rise(v[k-1]);
        check("dout", (k > 17) ? q[k-18] : 1'b0, dout);
        host.fall();
        q.push_back(v[k-1]);
        acc = {acc[14:0], v[k-1]};
      end
      check("dout", (n > 16) ? q[n-17] : 1'b0, dout);
      host.close_frame();
      if (n >= 16) exp_word = acc;
      cnt = 0;
      // Bounded wait for the update pulse
      for (int i = 0; i < 10; i++) begin
        @(posedge mclk);
        #1;
        if (word_upd !== 1'b0) cnt++;
      end
      check("word_upd", 16'(n >= 16), 16'(cnt));
      check("word_out", exp_word, word_out);
      check("dout", '0, dout);
      @(posedge mclk);
      $display("frame of %0d falls done", n);
    end
    wrap_up();
  end
endmodule
